// ===== design/xover_ctrl.sv
// Module: crossover, heartbeat, receive PLL and polarity control register bank
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Source select set: use register bits, ignore straps
// - Source select clear: take crossover from straps
// - Register bits 00 straight, 01 cross, 10 auto
// - Heartbeat test runs unless disable bit set
// - Hold bit keeps receive PLL on reference
// - No 10 Mb/s receive while PLL held
// - Read-only bit shows detected receive polarity
// - Port PHY reset returns control bits to default
// - All control bits read zero after reset
// - Hardware config register shows latched auto strap
// - Strap auto wins, else manual strap picks
// - Straps captured only at chip reset release
module xover_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [ADDR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic AUTO_STRAP,
  input wire logic MANUAL_STRAP,
  input wire logic TEN_RX_POLARITY_REVERSED,
  output logic XOVER_AUTO,
  output logic XOVER_CROSS,
  output logic HEARTBEAT_TEST_EN,
  output logic RX_PLL_REFERENCE_HOLD,
  output logic TEN_RX_ENABLE
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic crossover_source_select;
  logic crossover_auto_enable;
  logic crossover_manual_state;
  logic heartbeat_test_disable;
  logic rx_pll_reference_hold;
  logic ten_rx_polarity_reversed;
  logic auto_meta;
  logic auto_sync;
  logic manual_meta;
  logic manual_sync;
  logic auto_latched;
  logic manual_latched;
  logic port_reset;
  logic access;
  logic wr_hi;
  logic wr_lo;
  logic [31:0] next_dat;
  xover_ctrl_pkg::xover_e next_mode;

  // Word index of a byte address
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] adr);
    logic [31:0] wide;
    wide = 32'(adr);
    return wide[9:2];
  endfunction : word_index

  // Bus access in progress, not yet answered
  assign access = CYC_I && STB_I && !ACK_O;
  assign wr_hi = access && WE_I && SEL_I[1];
  assign wr_lo = access && WE_I && SEL_I[0];

  // ---------------------------------------------------------------
  // Pin synchronisers and strap capture
  // ---------------------------------------------------------------
  // Strap pins pass two flops; left free running so valid at release
  always_ff @(posedge CLK) begin
    auto_meta <= AUTO_STRAP;
    auto_sync <= auto_meta;
    manual_meta <= MANUAL_STRAP;
    manual_sync <= manual_meta;
  end

  // Straps follow the synchronisers while chip reset is high and freeze
  // at its release; a later strap change waits for the next chip reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      auto_latched <= auto_sync;
      manual_latched <= manual_sync;
    end
  end

  // Polarity status from the 10 Mb/s receiver on this clock
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ten_rx_polarity_reversed <= 1'b0;
    end else begin
      ten_rx_polarity_reversed <= TEN_RX_POLARITY_REVERSED;
    end
  end

  // ---------------------------------------------------------------
  // Port PHY reset from the reset control register
  // ---------------------------------------------------------------
  // Self-clearing one-cycle pulse on a write of one
  always_ff @(posedge CLK) begin
    if (RESET) begin
      port_reset <= 1'b0;
    end else begin
      port_reset <= wr_lo && word_index(ADR_I) == xover_ctrl_pkg::RSTCTL_INDEX
                    && DAT_I[xover_ctrl_pkg::PORT_RST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  // Writable bits; chip reset and port reset restore defaults
  always_ff @(posedge CLK) begin
    if (RESET || port_reset) begin
      crossover_source_select <= xover_ctrl_pkg::CTRL_BIT_RESET;
      crossover_auto_enable <= xover_ctrl_pkg::CTRL_BIT_RESET;
      crossover_manual_state <= xover_ctrl_pkg::CTRL_BIT_RESET;
      heartbeat_test_disable <= xover_ctrl_pkg::CTRL_BIT_RESET;
      rx_pll_reference_hold <= xover_ctrl_pkg::CTRL_BIT_RESET;
    end else if (wr_hi && word_index(ADR_I) == xover_ctrl_pkg::CTRL_INDEX) begin
      // Only defined bits are stored; reserved positions drop
      crossover_source_select <= DAT_I[xover_ctrl_pkg::SRC_SEL_BIT];
      crossover_auto_enable <= DAT_I[xover_ctrl_pkg::AUTO_EN_BIT];
      crossover_manual_state <= DAT_I[xover_ctrl_pkg::MAN_STATE_BIT];
      heartbeat_test_disable <= DAT_I[xover_ctrl_pkg::HB_OFF_BIT];
      rx_pll_reference_hold <= DAT_I[xover_ctrl_pkg::PLL_HOLD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Crossover mode selection
  // ---------------------------------------------------------------
  // Register source or strap source
  always_comb begin
    next_mode = xover_ctrl_pkg::XO_STRAIGHT;
    if (crossover_source_select) begin
      case ({crossover_auto_enable, crossover_manual_state})
        2'b00: next_mode = xover_ctrl_pkg::XO_STRAIGHT;
        2'b01: next_mode = xover_ctrl_pkg::XO_CROSS;
        2'b10: next_mode = xover_ctrl_pkg::XO_AUTO;
        default: next_mode = xover_ctrl_pkg::XO_STRAIGHT; // Forbidden 11
      endcase
    end else if (auto_latched) begin
      next_mode = xover_ctrl_pkg::XO_AUTO;
    end else if (manual_latched) begin
      next_mode = xover_ctrl_pkg::XO_CROSS;
    end
  end

  // Datapath controls, all from flops
  always_ff @(posedge CLK) begin
    if (RESET) begin
      XOVER_AUTO <= 1'b0;
      XOVER_CROSS <= 1'b0;
      HEARTBEAT_TEST_EN <= 1'b1;
      RX_PLL_REFERENCE_HOLD <= 1'b0;
      TEN_RX_ENABLE <= 1'b1;
    end else begin
      XOVER_AUTO <= next_mode == xover_ctrl_pkg::XO_AUTO;
      XOVER_CROSS <= next_mode == xover_ctrl_pkg::XO_CROSS;
      HEARTBEAT_TEST_EN <= !heartbeat_test_disable;
      RX_PLL_REFERENCE_HOLD <= rx_pll_reference_hold;
      TEN_RX_ENABLE <= !rx_pll_reference_hold;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone read data and acknowledge
  // ---------------------------------------------------------------
  // Read mux; unmapped words and reserved bits read zero
  always_comb begin
    next_dat = xover_ctrl_pkg::READ_ZERO;
    case (word_index(ADR_I))
      xover_ctrl_pkg::CTRL_INDEX: begin
        next_dat[xover_ctrl_pkg::SRC_SEL_BIT] = crossover_source_select;
        next_dat[xover_ctrl_pkg::AUTO_EN_BIT] = crossover_auto_enable;
        next_dat[xover_ctrl_pkg::MAN_STATE_BIT] = crossover_manual_state;
        next_dat[xover_ctrl_pkg::HB_OFF_BIT] = heartbeat_test_disable;
        next_dat[xover_ctrl_pkg::PLL_HOLD_BIT] = rx_pll_reference_hold;
        next_dat[xover_ctrl_pkg::POL_BIT] = ten_rx_polarity_reversed;
      end
      xover_ctrl_pkg::HWCFG_INDEX: begin
        next_dat[xover_ctrl_pkg::HW_AUTO_STRAP_BIT] = auto_latched;
        next_dat[xover_ctrl_pkg::HW_MAN_STRAP_BIT] = manual_latched;
      end
      default: next_dat = xover_ctrl_pkg::READ_ZERO;
    endcase
  end

  // One-cycle ack one edge after the request; every address answers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= access;
    end
  end

  // Read data registered alongside the ack
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DAT_O <= xover_ctrl_pkg::READ_ZERO;
    end else if (access) begin
      DAT_O <= WE_I ? xover_ctrl_pkg::READ_ZERO : next_dat;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_reg_cross_mode: assert property (
    @(posedge CLK) disable iff (RESET)
    crossover_source_select && !crossover_auto_enable && crossover_manual_state
    |=> XOVER_CROSS && !XOVER_AUTO)
    else $error("Register crossover state not applied");

  chk_reg_auto_mode: assert property (
    @(posedge CLK) disable iff (RESET)
    crossover_source_select && crossover_auto_enable && !crossover_manual_state
    |=> XOVER_AUTO && !XOVER_CROSS)
    else $error("Register auto crossover not applied");

  chk_strap_mode: assert property (
    @(posedge CLK) disable iff (RESET)
    !crossover_source_select
    |=> XOVER_AUTO == $past(auto_latched)
        && XOVER_CROSS == ($past(!auto_latched) && $past(manual_latched)))
    else $error("Strap crossover not applied");

  chk_heartbeat_off: assert property (
    @(posedge CLK) disable iff (RESET)
    wr_hi && word_index(ADR_I) == xover_ctrl_pkg::CTRL_INDEX
    && DAT_I[xover_ctrl_pkg::HB_OFF_BIT]
    |=> ##1 !HEARTBEAT_TEST_EN || $past(port_reset, 2))
    else $error("Heartbeat test not disabled after write");

  chk_pll_no_rx: assert property (
    @(posedge CLK) disable iff (RESET)
    (RX_PLL_REFERENCE_HOLD == !TEN_RX_ENABLE)
    and (rx_pll_reference_hold |=> RX_PLL_REFERENCE_HOLD))
    else $error("Receive allowed while PLL held");

  chk_polarity_read: assert property (
    @(posedge CLK) disable iff (RESET)
    access && !WE_I && word_index(ADR_I) == xover_ctrl_pkg::CTRL_INDEX
    |=> ACK_O && DAT_O[xover_ctrl_pkg::POL_BIT] == $past(ten_rx_polarity_reversed))
    else $error("Polarity bit wrong on read");

  chk_port_reset: assert property (
    @(posedge CLK) disable iff (RESET)
    port_reset |=> !crossover_source_select && !crossover_auto_enable
                   && !crossover_manual_state && !heartbeat_test_disable
                   && !rx_pll_reference_hold)
    else $error("Port reset did not clear control bits");

  chk_reset_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) |-> !crossover_source_select && !crossover_auto_enable
                     && !crossover_manual_state && !heartbeat_test_disable
                     && !rx_pll_reference_hold)
    else $error("Control bits not zero after reset");

  chk_hwcfg_read: assert property (
    @(posedge CLK) disable iff (RESET)
    access && !WE_I && word_index(ADR_I) == xover_ctrl_pkg::HWCFG_INDEX
    |=> DAT_O[xover_ctrl_pkg::HW_AUTO_STRAP_BIT] == auto_latched)
    else $error("Latched auto strap not reported");

  chk_strap_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    !$past(RESET) |-> $stable(auto_latched) && $stable(manual_latched))
    else $error("Strap value changed outside reset release");

  chk_reserved_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    access && !WE_I && word_index(ADR_I) == xover_ctrl_pkg::CTRL_INDEX
    |=> DAT_O[31:16] == 16'h0000 && DAT_O[12] == 1'b0
        && DAT_O[9:5] == 5'h00 && DAT_O[3:0] == 4'h0)
    else $error("Reserved bits not zero");

  chk_ack_single: assert property (
    @(posedge CLK) disable iff (RESET)
    ACK_O |=> !ACK_O)
    else $error("Ack held longer than one cycle");

endmodule : xover_ctrl

`default_nettype wire

// ===== design/xover_ctrl_pkg.sv
// Package: register map, field positions and reset values of the crossover control block
package xover_ctrl_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_INDEX = 8'h1b;
  localparam logic [7:0] HWCFG_INDEX = 8'h1d;
  localparam logic [7:0] RSTCTL_INDEX = 8'h1e;
  // ---------------------------------------------------------------
  // Field positions of the crossover/polarity control register
  // ---------------------------------------------------------------
  localparam int SRC_SEL_BIT = 15;
  localparam int AUTO_EN_BIT = 14;
  localparam int MAN_STATE_BIT = 13;
  localparam int HB_OFF_BIT = 11;
  localparam int PLL_HOLD_BIT = 10;
  localparam int POL_BIT = 4;
  // Field positions of the hardware configuration register
  localparam int HW_AUTO_STRAP_BIT = 0;
  localparam int HW_MAN_STRAP_BIT = 1;
  // Field position of the reset control register
  localparam int PORT_RST_BIT = 1;
  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic CTRL_BIT_RESET = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // Crossover behaviour presented to the datapath
  typedef enum logic [1:0] {XO_STRAIGHT, XO_CROSS, XO_AUTO} xover_e;
endpackage : xover_ctrl_pkg

// ===== tb/mgmt_host.sv
// Management host model issuing classic single-cycle bus accesses
`timescale 1ns/100ps
`default_nettype none

module mgmt_host (
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] dat_r,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat_w
);
  // Idle bus from time zero
  initial begin
    {cyc, stb, we, adr, sel, dat_w} = 47'h0;
  end

  // One access: request held until ack is sampled, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    logic [31:0] dd;
    dd = d;
    if (w && a == 8'h6c && d[14] && d[13]) begin
      dd[13] = 1'b0; // Never both crossover bits at once
    end
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat_w} <= {2'h3, w, a, s, dd};
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = dat_r;
    {cyc, stb, we} <= 3'h0;
  endtask : xfer
endmodule : mgmt_host

`default_nettype wire

// ===== tb/xover_ctrl_bench.sv
// Self-checking bench of the crossover control register bank
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module xover_ctrl_bench;
  logic clk, reset, cyc, stb, we, ack, a_strap, m_strap, pol;
  logic x_auto, x_cross, hb_en, hold, rx_en;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  int n_mismatch = 0;
  int tests_run = 0;
  localparam logic [7:0] A_CTRL = 8'h6c;
  localparam logic [7:0] A_HW = 8'h74;
  localparam logic [7:0] A_RST = 8'h78;

  xover_ctrl i_dut (.CLK(clk), .RESET(reset), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .AUTO_STRAP(a_strap), .MANUAL_STRAP(m_strap), .TEN_RX_POLARITY_REVERSED(pol),
    .XOVER_AUTO(x_auto), .XOVER_CROSS(x_cross), .HEARTBEAT_TEST_EN(hb_en),
    .RX_PLL_REFERENCE_HOLD(hold), .TEN_RX_ENABLE(rx_en));
  mgmt_host i_host (.clk(clk), .ack(ack), .dat_r(dat_r), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .dat_w(dat_w));

  // ---------------------------------------------------------------
  // Clock, access and check helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, s, q);
    repeat (2) @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, 4'hf, q);
    `CHK("read data", ex, q)
  endtask : rd

  // Datapath outputs: auto, cross, heartbeat, pll hold; rx enable is inverse of hold
  task automatic outs(input logic au, input logic cr, input logic hb, input logic ho);
    `CHK("xover", {au, cr}, {x_auto, x_cross})
    `CHK("heartbeat", hb, hb_en)
    `CHK("pll hold", {ho, ~ho}, {hold, rx_en})
  endtask : outs

  task automatic do_reset();
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_after_reset();
    rd(A_CTRL, 32'h0);
    outs(1'b0, 1'b1, 1'b1, 1'b0);
    rd(A_HW, 32'h2);
  endtask : t_after_reset

  // Strap change without reset is ignored; new reset latches it
  task automatic t_strap_latch();
    a_strap <= 1'b1;
    m_strap <= 1'b0;
    repeat (5) @(posedge clk);
    outs(1'b0, 1'b1, 1'b1, 1'b0);
    rd(A_HW, 32'h2);
    do_reset();
    outs(1'b1, 1'b0, 1'b1, 1'b0);
    rd(A_HW, 32'h1);
  endtask : t_strap_latch

  // Register modes 00, 01, 10 override the auto strap
  task automatic t_reg_modes();
    for (int i = 0; i < 3; i++) begin
      wr(A_CTRL, {16'h0, 1'b1, i[1:0], 13'h0}, 4'h2);
      outs(i == 2, i == 1, 1'b1, 1'b0);
    end
    wr(A_CTRL, 32'h0, 4'h2);
    outs(1'b1, 1'b0, 1'b1, 1'b0);
  endtask : t_reg_modes

  task automatic t_hb_pll_pol();
    wr(A_CTRL, 32'h0c00, 4'h2);
    outs(1'b1, 1'b0, 1'b0, 1'b1);
    pol <= 1'b1;
    repeat (2) @(posedge clk);
    rd(A_CTRL, 32'h0c10);
    pol <= 1'b0;
    repeat (2) @(posedge clk);
    rd(A_CTRL, 32'h0c00);
  endtask : t_hb_pll_pol

  // Reserved bits, unmapped place, then port reset clears control bits
  task automatic t_reserved_rst();
    wr(A_CTRL, 32'hffff_dfff, 4'hf);
    rd(A_CTRL, 32'hcc00);
    outs(1'b1, 1'b0, 1'b0, 1'b1);
    wr(8'h40, 32'hffff_ffff, 4'hf);
    rd(8'h40, 32'h0);
    rd(A_CTRL, 32'hcc00);
    wr(A_RST, 32'h2, 4'h1);
    rd(A_CTRL, 32'h0);
    outs(1'b1, 1'b0, 1'b1, 1'b0);
  endtask : t_reserved_rst

  // Main sequence
  initial begin
    reset = 1'b1;
    a_strap = 1'b0;
    m_strap = 1'b1;
    pol = 1'b0;
    do_reset();
    t_after_reset();
    t_strap_latch();
    t_reg_modes();
    t_hb_pll_pol();
    t_reserved_rst();
    tally_and_finish();
  end

  // Watchdog against a hung access
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : xover_ctrl_bench

`default_nettype wire
